// >>> rtl/power_seq_device.sv
// module-side power on, shutdown and reset sequencer
`timescale 1ns/1ns
module power_seq_device #(
	parameter int unsigned reset_hold = power_seq_pkg::reset_hold_cycles,
	parameter int unsigned boot_time = power_seq_pkg::boot_time_cycles,
	parameter int unsigned finalize_time = power_seq_pkg::finalize_cycles_default
) (
	input wire logic clock,
	input wire logic nrst,
	power_seq_if.device link,
	input wire logic shutdown_indication_cmd,
	input wire logic fast_trigger_assign,
	input wire logic main_supply,
	output logic fully_operational
);
	// ****************************************
	// synchronisers
	// ****************************************
	logic [1:0] on_sync;
	logic [1:0] rst_sync;
	logic [1:0] trig_sync;
	logic trig_prev;
	// pins come from the host's domain, two flops each
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			on_sync <= 2'h0;
			rst_sync <= 2'h3;
			trig_sync <= 2'h0;
			trig_prev <= 1'h0;
		end
		else
		begin
			on_sync <= {on_sync[0], link.power_on};
			rst_sync <= {rst_sync[0], link.hard_reset_in};
			trig_sync <= {trig_sync[0], link.fast_trigger};
			trig_prev <= trig_sync[1];
		end
	end
	wire on_level = on_sync[1];
	wire reset_low = ~rst_sync[1];
	// ****************************************
	// configuration latches
	// ****************************************
	logic indication_en;
	logic fast_en;
	// both functions come up disabled and are armed by configuration
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			indication_en <= 1'h0;
			fast_en <= 1'h0;
		end
		else
		begin
			if (shutdown_indication_cmd)
				indication_en <= 1'h1;
			if (fast_trigger_assign)
				fast_en <= 1'h1;
		end
	end
	// ****************************************
	// reset-low timer
	// ****************************************
	logic [power_seq_pkg::count_width-1:0] low_count;
	logic long_low;
	// pulses shorter than the hold time leave no trace
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			low_count <= '0;
			long_low <= 1'h0;
		end
		else if (reset_low)
		begin
			if (low_count < reset_hold[power_seq_pkg::count_width-1:0])
				low_count <= low_count + 1'b1;
			else
				long_low <= 1'h1;
		end
		else
		begin
			low_count <= '0;
			long_low <= 1'h0;
		end
	end
	wire restart_release = long_low & ~reset_low;
	wire fast_edge = fast_en & trig_prev & ~trig_sync[1];
	// ****************************************
	// sequencer
	// ****************************************
	power_seq_pkg::dev_state_t state;
	power_seq_pkg::dev_state_t next_state;
	logic [power_seq_pkg::count_width-1:0] timer;
	logic fast_done;
	wire boot_done = timer >= boot_time[power_seq_pkg::count_width-1:0];
	wire fin_done = timer >= finalize_time[power_seq_pkg::count_width-1:0];
	// next state, restart release outranks everything
	always_comb
	begin
		next_state = state;
		case (state)
			power_seq_pkg::st_off:
				if (main_supply && (on_level || reset_low))
					next_state = power_seq_pkg::st_boot;
			power_seq_pkg::st_boot:
				if (boot_done)
					next_state = power_seq_pkg::st_ready;
				else if (fast_edge)
					next_state = power_seq_pkg::st_finalize;
			power_seq_pkg::st_ready:
				if (!on_level || fast_edge)
					next_state = power_seq_pkg::st_finalize;
			power_seq_pkg::st_finalize:
				if (fin_done)
					next_state = power_seq_pkg::st_down;
			power_seq_pkg::st_down:
				// supply kept, on/off still high, unless a fast stop with indicator enabled: reboot
				if (on_level && !(fast_done && indication_en))
					next_state = power_seq_pkg::st_boot;
				else if (reset_low)
					next_state = power_seq_pkg::st_boot;
			power_seq_pkg::st_restart:
				next_state = power_seq_pkg::st_boot;
			default:
				next_state = power_seq_pkg::st_off;
		endcase
		if (restart_release)
			next_state = power_seq_pkg::st_restart;
		else if (!main_supply)
			next_state = power_seq_pkg::st_off;
	end
	// state, phase timer and fast-shutdown memory
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= power_seq_pkg::st_off;
			timer <= '0;
			fast_done <= 1'h0;
		end
		else
		begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + 1'b1;
			if (state == power_seq_pkg::st_boot || state == power_seq_pkg::st_ready)
				fast_done <= fast_edge;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	logic rail;
	logic status;
	logic operational;
	// rail follows the on states; status is high only in ready with indication enabled, low in every other state
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rail <= 1'h0;
			status <= 1'h0;
			operational <= 1'h0;
		end
		else
		begin
			rail <= next_state == power_seq_pkg::st_boot || next_state == power_seq_pkg::st_ready ||
				next_state == power_seq_pkg::st_finalize;
			status <= indication_en && next_state == power_seq_pkg::st_ready;
			operational <= next_state == power_seq_pkg::st_ready;
		end
	end
	assign link.reference_rail_out = rail;
	assign link.boot_status = status;
	assign fully_operational = operational;
endmodule

// >>> rtl/power_seq_host.sv
// host-side controller driving the module power pins
`timescale 1ns/1ns
module power_seq_host #(
	parameter int unsigned reset_hold = power_seq_pkg::reset_hold_cycles,
	parameter int unsigned boot_time = power_seq_pkg::boot_time_cycles
) (
	input wire logic clock,
	input wire logic nrst,
	power_seq_if.host link,
	input wire logic power_request,
	input wire logic fast_request,
	input wire logic emergency_reset,
	output logic may_communicate,
	output logic module_rail
);
	// ****************************************
	// pin inputs
	// ****************************************
	logic [1:0] rail_sync;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rail_sync <= 2'h0;
		else
			rail_sync <= {rail_sync[0], link.reference_rail_out};
	end
	// ****************************************
	// sequencer
	// ****************************************
	power_seq_pkg::host_state_t state;
	power_seq_pkg::host_state_t next_state;
	logic [power_seq_pkg::count_width-1:0] timer;
	wire rail_up = rail_sync[1];
	wire held = timer > reset_hold[power_seq_pkg::count_width-1:0];
	wire booted = timer >= boot_time[power_seq_pkg::count_width-1:0];
	always_comb
	begin
		next_state = state;
		case (state)
			power_seq_pkg::h_idle:
				if (power_request)
					next_state = power_seq_pkg::h_power;
			power_seq_pkg::h_power:
				next_state = power_seq_pkg::h_wait;
			power_seq_pkg::h_wait:
				if (booted)
					next_state = power_seq_pkg::h_run;
			power_seq_pkg::h_run:
				if (!power_request || fast_request)
					next_state = power_seq_pkg::h_stop;
			power_seq_pkg::h_stop:
				if (!rail_up && !power_request)
					next_state = power_seq_pkg::h_idle;
			power_seq_pkg::h_reset:
				if (held)
					next_state = power_seq_pkg::h_wait;
			default:
				next_state = power_seq_pkg::h_idle;
		endcase
		if (emergency_reset && state != power_seq_pkg::h_reset)
			next_state = power_seq_pkg::h_reset;
	end
	logic on_pin;
	logic pull_low;
	logic trig;
	logic ok;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= power_seq_pkg::h_idle;
			timer <= '0;
			on_pin <= 1'h0;
			pull_low <= 1'h0;
			trig <= 1'h0;
			ok <= 1'h0;
		end
		else
		begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + 1'b1;
			// on/off low in stop keeps the module from rebooting
			// on/off follows the request except in reset, where it is low; held in stop only while the rail is still up
			on_pin <= power_request && next_state != power_seq_pkg::h_idle && next_state != power_seq_pkg::h_reset &&
				(next_state != power_seq_pkg::h_stop || rail_up);
			pull_low <= next_state == power_seq_pkg::h_reset;
			// trigger idles high only while module is up, falls to request fast stop
			trig <= next_state == power_seq_pkg::h_run && !fast_request;
			ok <= next_state == power_seq_pkg::h_run;
		end
	end
	assign link.power_on = on_pin;
	assign link.reset_drive_oe = pull_low;
	assign link.fast_trigger = trig;
	assign may_communicate = ok;
	assign module_rail = rail_up;
endmodule

// >>> rtl/power_seq_if.sv
// pins between the host controller and the module sequencer
`timescale 1ns/1ns
interface power_seq_if;
	logic power_on; // on/off input, high means on
	logic reset_drive_oe; // host open-collector pull-down active
	logic fast_trigger; // gpio assigned as fast shutdown trigger
	logic boot_status; // boot done / shutdown indicator
	logic reference_rail_out; // rail high while module is on
	wire hard_reset_in = ~reset_drive_oe; // internal pull-up, host only pulls low
	modport device (input power_on, input hard_reset_in, input fast_trigger, output boot_status,
		output reference_rail_out);
	modport host (output power_on, output reset_drive_oe, output fast_trigger, input boot_status,
		input reference_rail_out, input hard_reset_in);
endinterface

// >>> rtl/power_seq_pkg.sv
// constants and types shared by both ends of the power sequencing link
package power_seq_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned clock_hz = 50000000;
	localparam int unsigned reset_hold_ms = 1000; // least low time that restarts
	localparam int unsigned boot_time_ms = 50000; // least time to fully operational
	localparam int unsigned reset_hold_cycles = reset_hold_ms * (clock_hz / 1000);
	localparam int unsigned boot_time_cycles = boot_time_ms * (clock_hz / 1000);
	localparam int unsigned finalize_cycles_default = 1000;
	localparam int unsigned count_width = 32;
	// ****************************************
	// states
	// ****************************************
	typedef enum logic [2:0] {st_off, st_boot, st_ready, st_finalize, st_down, st_restart} dev_state_t;
	typedef enum logic [2:0] {h_idle, h_power, h_wait, h_run, h_stop, h_reset} host_state_t;
endpackage

// >>> tb/module_power_sequencer_test.sv
// self-checking bench joining host and module sequencers
`timescale 1ns/1ns
module module_power_sequencer_test;
	localparam int unsigned hold = 20;
	localparam int unsigned boot = 200;
	logic clock;
	logic nrst;
	logic ind_cmd;
	logic assign_cmd;
	logic supply;
	logic power_request;
	logic fast_request;
	logic emergency_reset;
	logic fully_operational;
	logic may_communicate;
	logic module_rail;
	int bad_count;
	int tests_run;
	power_seq_if link();
	power_seq_device #(.reset_hold(hold), .boot_time(boot), .finalize_time(10)) u_power_seq_device (
		.clock(clock), .nrst(nrst), .link(link), .shutdown_indication_cmd(ind_cmd),
		.fast_trigger_assign(assign_cmd), .main_supply(supply), .fully_operational(fully_operational));
	power_seq_host #(.reset_hold(hold), .boot_time(boot)) u_power_seq_host (
		.clock(clock), .nrst(nrst), .link(link), .power_request(power_request), .fast_request(fast_request),
		.emergency_reset(emergency_reset), .may_communicate(may_communicate), .module_rail(module_rail));
	power_seq_checker #(.reset_hold(hold)) u_power_seq_checker (
		.clock(clock), .nrst(nrst), .power_on(link.power_on), .reset_drive_oe(link.reset_drive_oe),
		.fast_trigger(link.fast_trigger), .boot_status(link.boot_status),
		.reference_rail_out(link.reference_rail_out), .hard_reset_in(link.hard_reset_in));
	// 50 MHz clock
	initial
	begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	// ****
	// shared tasks
	// ****
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	// fresh reset each test, since the option enables only clear on nrst
	task automatic start(input logic ind, input logic asg);
		nrst = 0;
		power_request = 0;
		fast_request = 0;
		emergency_reset = 0;
		ind_cmd = ind;
		assign_cmd = asg;
		cyc(4);
		nrst = 1;
		cyc(2);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_plain;
		start(0, 0);
		power_request = 1;
		cyc(100);
		chk("rail in boot", link.reference_rail_out, 1);
		chk("ready early", fully_operational, 0);
		cyc(150);
		chk("ready", fully_operational, 1);
		chk("may talk", may_communicate, 1);
		chk("status off", link.boot_status, 0);
		fast_request = 1;
		cyc(40);
		chk("fast unassigned", link.reference_rail_out, 1);
		fast_request = 0;
		power_request = 0;
		cyc(40);
		chk("graceful", link.reference_rail_out, 0);
		chk("host rail", module_rail, 0);
		$display("test plain done");
	endtask
	// stop request during boot must not take effect
	task automatic t_early;
		start(0, 0);
		power_request = 1;
		cyc(50);
		power_request = 0;
		cyc(40);
		chk("early stop", link.reference_rail_out, 1);
		$display("test early done");
	endtask
	task automatic t_fast;
		start(1, 1);
		power_request = 1;
		cyc(250);
		chk("boot status", link.boot_status, 1);
		fast_request = 1;
		cyc(40);
		chk("fast stop", link.reference_rail_out, 0);
		cyc(300);
		chk("no reboot", link.reference_rail_out, 0);
		$display("test fast done");
	endtask
	task automatic t_reset;
		start(1, 0);
		power_request = 1;
		cyc(250);
		emergency_reset = 1;
		cyc(30);
		emergency_reset = 0;
		cyc(10);
		chk("restarted", fully_operational, 0);
		cyc(260);
		chk("reboot done", fully_operational, 1);
		power_request = 0;
		cyc(40);
		chk("graceful ind", link.reference_rail_out, 0);
		emergency_reset = 1;
		cyc(10);
		chk("reset powers on", link.reference_rail_out, 1);
		emergency_reset = 0;
		cyc(40);
		$display("test reset done");
	endtask
	// hang guard, several times the expected run
	initial
	begin
		cyc(6000);
		bad_count++;
		complete_run();
	end
	initial
	begin
		bad_count = 0;
		tests_run = 0;
		supply = 1;
		t_plain();
		t_early();
		t_fast();
		t_reset();
		complete_run();
	end
endmodule

// >>> tb/power_seq_asserts.sv
// concurrent checks on the pins between host and module sequencers
`timescale 1ns/1ns
module power_seq_checker #(
	parameter int unsigned reset_hold = 20
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic power_on,
	input wire logic reset_drive_oe,
	input wire logic fast_trigger,
	input wire logic boot_status,
	input wire logic reference_rail_out,
	input wire logic hard_reset_in
);
	int unsigned low_count;
	// length of the reset-low stretch, still visible at the release edge
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			low_count <= 0;
		else if (!hard_reset_in)
			low_count <= low_count + 1;
		else
			low_count <= 0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// ****
	// pin relations
	// ****
	power_on_boot_a: assert property ($rose(power_on) && !reference_rail_out |-> ##[1:6] reference_rail_out)
		else $error("rail did not rise after power on");
	reset_kept_high_a: assert property ($rose(power_on) |-> !reset_drive_oe)
		else $error("reset pulled during power on");
	reset_powers_on_a: assert property ($fell(hard_reset_in) && !reference_rail_out && !power_on
		|-> ##[1:8] reference_rail_out)
		else $error("reset low did not power on");
	long_reset_a: assert property ($rose(hard_reset_in) && low_count > reset_hold |-> ##[1:6] !boot_status)
		else $error("long reset did not restart");
	status_needs_rail_a: assert property (boot_status |-> reference_rail_out)
		else $error("boot status high while rail off");
	graceful_stop_a: assert property ($fell(power_on) && boot_status
		|-> reference_rail_out [*8] ##[1:14] !reference_rail_out)
		else $error("graceful stop timing wrong");
	// a trigger that falls because of an emergency reset is not a fast stop request
	fast_stop_a: assert property ($fell(fast_trigger) && boot_status && !reset_drive_oe
		|-> ##[1:20] !reference_rail_out)
		else $error("fast stop did not drop rail");
	quiet_when_off_a: assert property ((!reference_rail_out) [*6] |-> !fast_trigger)
		else $error("trigger high while module off");
	short_reset_a: assert property ($rose(hard_reset_in) && low_count < reset_hold && boot_status
		|-> boot_status [*8])
		else $error("short reset pulse acted on");
endmodule
